// ---- include/dsc_pkg.sv ----
package dsc_pkg;
	localparam logic [5:0] OFF_A_CTRL = 6'h00;
	localparam logic [5:0] OFF_A_BAUD = 6'h04;
	localparam logic [5:0] OFF_A_TX   = 6'h08;
	localparam logic [5:0] OFF_A_RX   = 6'h0C;
	localparam logic [5:0] OFF_S_CTRL = 6'h10;
	localparam logic [5:0] OFF_S_BAUD = 6'h14;
	localparam logic [5:0] OFF_S_TX   = 6'h18;
	localparam logic [5:0] OFF_S_RX   = 6'h1C;
	localparam logic [5:0] OFF_ISTAT  = 6'h20;
	localparam logic [5:0] OFF_ICLR   = 6'h24;
	localparam logic [5:0] OFF_IEN    = 6'h28;
	localparam logic [5:0] OFF_STATE  = 6'h2C;

	localparam int A_EN    = 0;
	localparam int A_SYNC  = 1;
	localparam int A_N9    = 2;
	localparam int A_STOP2 = 3;
	localparam int A_PAR   = 4;
	localparam int A_ODD   = 5;
	localparam int A_FEN   = 6;
	localparam int A_WAKE  = 7;
	localparam int A_FILT  = 8;
	localparam int A_LOOP  = 9;

	localparam int S_EN   = 0;
	localparam int S_MST  = 1;
	localparam int S_MSB  = 2;
	localparam int S_LOOP = 3;
	localparam int S_LEN  = 4;

	localparam int ST_ATX = 0;
	localparam int ST_ARX = 1;
	localparam int ST_APE = 2;
	localparam int ST_AFE = 3;
	localparam int ST_AOE = 4;
	localparam int ST_STX = 5;
	localparam int ST_SRX = 6;
	localparam int ST_SOE = 7;
	localparam int NST    = 8;

	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam logic [15:0] BAUD_RST   = 16'h0018;
	localparam logic [3:0]  OVS_LAST   = 4'hF;
	localparam logic [3:0]  OVS_MID    = 4'h7;
	localparam logic [3:0]  ASYNC_LAST = 4'h9;
	localparam logic [3:0]  SYNC_LAST  = 4'h7;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_BITS = 2'b01
	} dsc_rx_t;
endpackage : dsc_pkg

// ---- rtl/dsc_baud.sv ----
`timescale 1ns/1ps
module dsc_baud
	import dsc_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         run,
	input  wire logic [W-1:0] reload,
	output logic              tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} dsc_bst_t;

	dsc_bst_t s;
	dsc_bst_t next_s;

	// One tick every reload+1 clocks while running.
	always_comb begin
		next_s      = s;
		next_s.tick = 1'b0;
		if (!run) begin
			next_s.cnt = reload;
		end else if (s.cnt == '0) begin
			next_s.cnt  = reload;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_tick_gap;
		tick && reload != '0 && $stable(reload) |=> !tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("baud ticks too close");

	property p_reload;
		run && s.cnt == '0 |=> tick && s.cnt == $past(reload);
	endproperty
	a_reload: assert property (p_reload) else $error("baud reload missed");
endmodule : dsc_baud

// ---- rtl/dsc_top.sv ----
`timescale 1ns/1ps
module dsc_top
	import dsc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             asc_txd,
	input  wire logic        asc_rxd,
	output logic             asc_sclk,
	output logic             ssc_tx,
	input  wire logic        ssc_rx,
	input  wire logic        ssc_sclk_i,
	output logic             ssc_sclk_o,
	output logic             ssc_sclk_oe_n,
	output logic [5:0]       irq_req,
	output logic             irq
);
	typedef struct packed {
		logic           aw_got;
		logic [5:0]     awa;
		logic           w_got;
		logic [31:0]    wd;
		logic [3:0]     ws;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           rvalid;
		logic [31:0]    rdata;
		logic [1:0]     rresp;
		logic [15:0]    a_ctrl;
		logic [15:0]    a_baud;
		logic [15:0]    s_ctrl;
		logic [15:0]    s_baud;
		logic [NST-1:0] stat;
		logic [NST-1:0] ien;
		logic           a_tb;
		logic [12:0]    a_tf;
		logic [3:0]     a_tn;
		logic [3:0]     a_ti;
		logic [3:0]     a_tp;
		logic           a_ck;
		logic           a_txd;
		dsc_rx_t        a_rs;
		logic [12:0]    a_rf;
		logic [3:0]     a_ri;
		logic [3:0]     a_rp;
		logic [8:0]     a_rd;
		logic           a_rfull;
		logic           s_b;
		logic [15:0]    s_td;
		logic [15:0]    s_rsh;
		logic [15:0]    s_rd;
		logic [3:0]     s_i;
		logic           s_ck;
		logic           s_ckp;
		logic           s_out;
		logic           s_rfull;
	} dsc_st_t;

	dsc_st_t        s;
	dsc_st_t        next_s;
	logic           a_tick;
	logic           s_tick;
	logic           a_n9;
	logic           a_sync;
	logic           a_line;
	logic [3:0]     a_rlast;
	logic [8:0]     a_rdat;
	logic [8:0]     a_tdat;
	logic           a_pbad;
	logic [3:0]     s_last;
	logic           s_master;
	logic           s_msb;
	logic           s_line;
	logic [3:0]     s_pos;
	logic [15:0]    s_mask;
	logic [NST-1:0] m;
	logic [NST-1:0] set;
	logic [NST-1:0] clr;
	logic [12:0]    a_fr;
	logic           wr_go;
	logic           a_load;
	logic           s_load;
	logic           a_start;
	logic           a_sdone;
	logic           a_rx_done;
	logic           a_take;
	logic           s_start;
	logic           s_rise;
	logic           s_fall;

	function automatic logic [15:0] merge(logic [15:0] o, logic [31:0] d, logic [3:0] b);
		merge = {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
	endfunction : merge

	// Reload values near 24 give 10 MHz ticks: 16x oversampling at 625 kBd, 5 MBd shifting.
	dsc_baud #(.W(16)) u_a_baud (
		.clk_sys(clk_sys),
		.rst    (rst),
		.run    (s.a_ctrl[A_EN]),
		.reload (s.a_baud),
		.tick   (a_tick)
	);
	dsc_baud #(.W(16)) u_s_baud (
		.clk_sys(clk_sys),
		.rst    (rst),
		.run    (s.s_ctrl[S_EN] & s_master),
		.reload (s.s_baud),
		.tick   (s_tick)
	);

	assign a_n9     = s.a_ctrl[A_N9] | s.a_ctrl[A_WAKE];
	assign a_sync   = s.a_ctrl[A_SYNC];
	assign a_line   = s.a_ctrl[A_LOOP] ? s.a_txd : asc_rxd;
	assign a_rlast  = ASYNC_LAST + {3'h0, a_n9} + {3'h0, s.a_ctrl[A_PAR]};
	assign a_rdat   = a_n9 ? s.a_rf[9:1] : {1'b0, s.a_rf[8:1]};
	assign a_tdat   = a_n9 ? s.wd[8:0] : {1'b0, s.wd[7:0]};
	assign a_pbad   = (^a_rdat ^ s.a_ctrl[A_ODD]) != s.a_rf[a_rlast - 4'h1];
	assign s_last   = (s.s_ctrl[S_LEN+:4] == 4'h0) ? 4'h1 : s.s_ctrl[S_LEN+:4];
	assign s_master = s.s_ctrl[S_MST];
	assign s_msb    = s.s_ctrl[S_MSB];
	assign s_line   = s.s_ctrl[S_LOOP] ? s.s_out : ssc_rx;
	assign s_pos    = s_msb ? s_last - s.s_i : s.s_i;
	assign s_mask   = 16'hFFFF >> (4'hF - s_last);
	assign m        = s.stat & s.ien;

	always_comb begin
		next_s    = s;
		set       = '0;
		clr       = '0;
		a_load    = 1'b0;
		s_load    = 1'b0;
		a_start   = 1'b0;
		a_sdone   = 1'b0;
		a_rx_done = 1'b0;
		s_start   = 1'b0;
		a_fr      = 13'h1FFF;
		wr_go     = s.aw_got && s.w_got && !s.bvalid;

		if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
			next_s.aw_got = 1'b1;
			next_s.awa    = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
			next_s.w_got = 1'b1;
			next_s.wd    = s_axi_wdata;
			next_s.ws    = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (wr_go) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = RESP_OKAY;
			case (s.awa)
			OFF_A_CTRL: next_s.a_ctrl = merge(s.a_ctrl, s.wd, s.ws);
			OFF_A_BAUD: next_s.a_baud = merge(s.a_baud, s.wd, s.ws);
			OFF_A_TX:   a_load = 1'b1;
			OFF_S_CTRL: next_s.s_ctrl = merge(s.s_ctrl, s.wd, s.ws);
			OFF_S_BAUD: next_s.s_baud = merge(s.s_baud, s.wd, s.ws);
			OFF_S_TX:   s_load = 1'b1;
			OFF_ICLR:   clr = s.wd[NST-1:0];
			OFF_IEN:    next_s.ien = s.wd[NST-1:0];
			OFF_A_RX, OFF_S_RX, OFF_ISTAT, OFF_STATE: next_s.bresp = RESP_OKAY;
			default:    next_s.bresp = RESP_SLVERR;
			endcase
		end

		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			next_s.rdata  = 32'h0000_0000;
			case (s_axi_araddr)
			OFF_A_CTRL: next_s.rdata[15:0] = s.a_ctrl;
			OFF_A_BAUD: next_s.rdata[15:0] = s.a_baud;
			OFF_A_RX: begin
				next_s.rdata[8:0] = s.a_rd;
				next_s.a_rfull    = 1'b0;
			end
			OFF_S_CTRL: next_s.rdata[15:0] = s.s_ctrl;
			OFF_S_BAUD: next_s.rdata[15:0] = s.s_baud;
			OFF_S_RX: begin
				next_s.rdata[15:0] = s.s_rd;
				next_s.s_rfull     = 1'b0;
			end
			OFF_ISTAT:  next_s.rdata[NST-1:0] = s.stat;
			OFF_IEN:    next_s.rdata[NST-1:0] = s.ien;
			OFF_STATE:  next_s.rdata[4:0] = {s.s_rfull, s.s_b, s.a_rfull, s.a_tb, s.a_rs[0]};
			OFF_A_TX, OFF_S_TX, OFF_ICLR: next_s.rresp = RESP_OKAY;
			default:    next_s.rresp = RESP_SLVERR;
			endcase
		end

		// Transmit frame, bit 0 leaves first.
		if (a_sync) begin
			a_fr = {5'h1F, s.wd[7:0]};
		end else begin
			a_fr[8:0] = {s.wd[7:0], 1'b0};
			a_fr[9]   = !a_n9 | s.wd[8];
			if (s.a_ctrl[A_PAR]) begin
				a_fr[ASYNC_LAST + {3'h0, a_n9}] = ^a_tdat ^ s.a_ctrl[A_ODD];
			end
		end

		if (a_load && s.a_ctrl[A_EN] && !s.a_tb) begin
			a_start     = 1'b1;
			next_s.a_tb = 1'b1;
			next_s.a_ti = 4'h0;
			next_s.a_tp = 4'h0;
			next_s.a_ck = 1'b0;
			next_s.a_tf = a_fr;
			next_s.a_tn = a_sync ? SYNC_LAST : a_rlast + {3'h0, s.a_ctrl[A_STOP2]};
		end else if (s.a_tb && a_tick && !a_sync) begin
			next_s.a_tp = s.a_tp + 4'h1;
			if (s.a_tp == OVS_LAST) begin
				if (s.a_ti == s.a_tn) begin
					next_s.a_tb   = 1'b0;
					set[ST_ATX] = 1'b1;
				end else begin
					next_s.a_ti = s.a_ti + 4'h1;
				end
			end
		end else if (s.a_tb && a_tick) begin
			// Sync mode: sample on the rising clock edge, shift on the falling one.
			next_s.a_ck = !s.a_ck;
			if (!s.a_ck) begin
				next_s.a_rf[s.a_ti] = a_line;
			end else if (s.a_ti == SYNC_LAST) begin
				next_s.a_tb   = 1'b0;
				set[ST_ATX] = 1'b1;
				a_sdone       = 1'b1;
			end else begin
				next_s.a_ti = s.a_ti + 4'h1;
			end
		end
		next_s.a_txd = next_s.a_tb ? next_s.a_tf[next_s.a_ti] : 1'b1;

		case (s.a_rs)
		RX_IDLE: begin
			if (s.a_ctrl[A_EN] && !a_sync && !a_line) begin
				next_s.a_rs = RX_BITS;
				next_s.a_ri = 4'h0;
				next_s.a_rp = 4'h0;
			end
		end
		RX_BITS: begin
			if (a_sync || !s.a_ctrl[A_EN]) begin
				next_s.a_rs = RX_IDLE;
			end else if (a_tick) begin
				next_s.a_rp = s.a_rp + 4'h1;
				if (s.a_rp == OVS_MID) begin
					next_s.a_rf[s.a_ri] = a_line;
					if (s.a_ri == 4'h0 && a_line) begin
						next_s.a_rs = RX_IDLE;
					end else if (s.a_ri == a_rlast) begin
						next_s.a_rs = RX_IDLE;
						a_rx_done   = 1'b1;
					end else begin
						next_s.a_ri = s.a_ri + 4'h1;
					end
				end
			end
		end
		default: next_s.a_rs = RX_IDLE;
		endcase

		// With wake-up and filter both set, asynchronous frames are delivered only with the ninth bit set.
		a_take = (a_rx_done && !(s.a_ctrl[A_WAKE] && s.a_ctrl[A_FILT] && !s.a_rf[9])) || a_sdone;
		if (a_take) begin
			next_s.a_rd    = a_sdone ? {1'b0, s.a_rf[7:0]} : a_rdat;
			next_s.a_rfull = 1'b1;
			set[ST_ARX]    = 1'b1;
			set[ST_AOE]    = s.a_rfull;
			set[ST_APE]    = a_rx_done && s.a_ctrl[A_PAR] && a_pbad;
			set[ST_AFE]    = a_rx_done && s.a_ctrl[A_FEN] && !a_line;
		end

		// High-speed channel: sample on rising clock, advance on falling clock.
		next_s.s_ckp = ssc_sclk_i;
		s_rise = s.s_ctrl[S_EN] && (s_master ? s.s_b && s_tick && !s.s_ck
			: ssc_sclk_i && !s.s_ckp);
		s_fall = s.s_ctrl[S_EN] && (s_master ? s.s_b && s_tick && s.s_ck
			: !ssc_sclk_i && s.s_ckp);
		if (s_master && s.s_b && s_tick) begin
			next_s.s_ck = !s.s_ck;
		end
		if (s_rise) begin
			next_s.s_rsh[s_pos] = s_line;
		end
		if (s_fall) begin
			if (s.s_i == s_last) begin
				next_s.s_i     = 4'h0;
				next_s.s_b     = 1'b0;
				next_s.s_rd    = s.s_rsh & s_mask;
				next_s.s_rfull = 1'b1;
				set[ST_SRX]    = 1'b1;
				set[ST_STX]    = s.s_b;
				set[ST_SOE]    = s.s_rfull;
			end else begin
				next_s.s_i = s.s_i + 4'h1;
			end
		end
		if (s_load && s.s_ctrl[S_EN] && !s.s_b) begin
			s_start     = 1'b1;
			next_s.s_td = s.wd[15:0];
			next_s.s_i  = 4'h0;
			next_s.s_b  = 1'b1;
		end
		next_s.s_out = next_s.s_td[s_msb ? s_last - next_s.s_i : next_s.s_i];

		next_s.stat = (s.stat & ~clr) | set;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s        <= '0;
			s.a_txd  <= 1'b1;
			s.a_ctrl <= CTRL_RST;
			s.s_ctrl <= CTRL_RST;
			s.a_baud <= BAUD_RST;
			s.s_baud <= BAUD_RST;
			s.a_rs   <= RX_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready  = !s.w_got && !s.bvalid;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign asc_txd       = s.a_txd;
	assign asc_sclk      = s.a_ck;
	assign ssc_tx        = s.s_out;
	assign ssc_sclk_o    = s.s_ck;
	assign ssc_sclk_oe_n = !s_master;
	assign irq_req       = {m[ST_SOE], m[ST_SRX], m[ST_STX],
		|m[ST_AOE:ST_APE], m[ST_ARX], m[ST_ATX]};
	assign irq           = |m;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_start_low;
		!asc_txd [*8];
	endsequence
	property p_start_bit;
		a_start && !a_sync |=> s_start_low;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("start bit not low");

	property p_parity;
		a_take && a_rx_done && s.a_ctrl[A_PAR] && a_pbad |=> s.stat[ST_APE];
	endproperty
	a_parity: assert property (p_parity) else $error("parity error not flagged");

	property p_frame;
		a_take && a_rx_done && s.a_ctrl[A_FEN] && !a_line |=> s.stat[ST_AFE];
	endproperty
	a_frame: assert property (p_frame) else $error("framing error not flagged");

	property p_overrun;
		a_take && s.a_rfull |=> s.stat[ST_AOE] && s.a_rfull;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_err_sticky;
		s.stat[ST_APE] && !clr[ST_APE] |=> s.stat[ST_APE];
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

	property p_err_req;
		s.stat[ST_AFE] && s.ien[ST_AFE] |-> irq_req[2] && irq;
	endproperty
	a_err_req: assert property (p_err_req) else $error("error request missing");

	property p_filter;
		a_rx_done && !a_take |=> $stable(s.a_rd);
	endproperty
	a_filter: assert property (p_filter) else $error("filtered frame delivered");

	property p_msb;
		s_start && s_msb |=> ssc_tx == s.s_td[s_last];
	endproperty
	a_msb: assert property (p_msb) else $error("msb not first");

	property p_master_edge;
		s_master && s.s_b && s_tick |=> $changed(ssc_sclk_o);
	endproperty
	a_master_edge: assert property (p_master_edge) else $error("master clock stalled");
endmodule : dsc_top

// ---- bench/dsc_far.sv ----
`timescale 1ns/1ps
module dsc_far
#(
	parameter int BIT = 16
) (
	input  wire logic        clk_sys,
	input  wire logic        asc_txd,
	output logic             asc_rxd,
	input  wire logic        ssc_sclk_o,
	input  wire logic        ssc_tx,
	output logic             ssc_rx,
	output logic [9:0]       got,
	output int               frames,
	output logic [15:0]      cap
);
	logic [15:0] pat;
	logic        sclk_q;

	assign ssc_rx = pat[15];

	initial begin
		asc_rxd = 1'b1;
		frames = 0;
		pat = '0;
		cap = '0;
		sclk_q = 1'b0;
	end

	// Ten mid-bit samples after each start bit, the stop bit included, and one idle bit after an eight-bit frame without parity.
	// Listening starts once reset has settled the line high, so no false frame is caught.
	initial begin
		repeat (BIT + 4) @(posedge clk_sys);
		forever begin
			@(negedge asc_txd);
			repeat (BIT / 2) @(posedge clk_sys);
			for (int i = 0; i < 10; i++) begin
				repeat (BIT) @(posedge clk_sys);
				got[i] = asc_txd;
			end
			frames++;
		end
	end

	// A slave on the master's clock: capture on rising, next bit out after falling.
	always @(posedge clk_sys) begin
		sclk_q <= ssc_sclk_o;
		if (ssc_sclk_o && !sclk_q) cap <= {cap[14:0], ssc_tx};
		if (!ssc_sclk_o && sclk_q) pat <= {pat[14:0], pat[15]};
	end

	task automatic load(input logic [15:0] v);
		pat <= v;
	endtask : load

	// Start bit, n bits LSB first, then the line rests high for two bit times.
	task automatic send(input logic [9:0] b, input int n);
		asc_rxd <= 1'b0;
		repeat (BIT) @(posedge clk_sys);
		for (int j = 0; j < n; j++) begin
			asc_rxd <= b[j];
			repeat (BIT) @(posedge clk_sys);
		end
		asc_rxd <= 1'b1;
		repeat (2 * BIT) @(posedge clk_sys);
	endtask : send
endmodule : dsc_far

// ---- bench/dual_serial_channels_tb.sv ----
`timescale 1ns/1ps
module dual_serial_channels_tb
	import dsc_pkg::*;
;
	typedef struct packed {
		logic [15:0] ctrl;
		logic [8:0]  data;
		logic [9:0]  line;
	} dsc_row_t;
	dsc_row_t    rows [5] = '{
		'{16'h1, 9'h055, 10'h355},
		'{16'h11, 9'h007, 10'h307},
		'{16'h31, 9'h007, 10'h207},
		'{16'h5, 9'h1A5, 10'h3A5},
		'{16'h81, 9'h0A5, 10'h2A5}
	};
	logic        clk_sys, rst;
	logic [5:0]  awaddr, araddr, irq_req;
	logic [31:0] wdata, rdata, rd;
	logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic        asc_txd, asc_rxd, asc_sclk, ssc_tx, ssc_rx, sclk_o, sclk_oe_n, irq;
	logic        bready, rready, sclk_i;
	logic [9:0]  got;
	logic [15:0] cap;
	int          frames, f0;
	int          err_total = 0;
	int          comparisons = 0;

	dsc_top i_dut (
		.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.asc_txd(asc_txd), .asc_rxd(asc_rxd), .asc_sclk(asc_sclk), .ssc_tx(ssc_tx),
		.ssc_rx(ssc_rx), .ssc_sclk_i(sclk_i), .ssc_sclk_o(sclk_o),
		.ssc_sclk_oe_n(sclk_oe_n), .irq_req(irq_req), .irq(irq)
	);
	dsc_far i_far (
		.clk_sys(clk_sys), .asc_txd(asc_txd), .asc_rxd(asc_rxd), .ssc_sclk_o(sclk_o),
		.ssc_tx(ssc_tx), .ssc_rx(ssc_rx), .got(got), .frames(frames), .cap(cap)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready || wvalid && !wready) && n < 500);
		do begin
			@(posedge clk_sys);
			n++;
		end while (!bvalid && n < 500);
		chk(32'(bresp), 32'(er));
		if (n >= 500) err_total++;
	endtask : wr

	task automatic rd_reg(input logic [5:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!arready && n < 500);
		arvalid <= 1'b0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!rvalid && n < 500);
		d = rdata;
		chk(32'(rresp), 32'(er));
		if (n >= 500) err_total++;
	endtask : rd_reg

	task automatic rchk(input logic [5:0] a, input logic [31:0] e);
		rd_reg(a, rd, RESP_OKAY);
		chk(rd, e);
	endtask : rchk

	// Polls the status register until the given event bit shows.
	task automatic wait_st(input int b);
		int n;
		n = 0;
		do begin
			rd_reg(OFF_ISTAT, rd, RESP_OKAY);
			n++;
		end while (!rd[b] && n < 2000);
		chk(32'(rd[b]), 32'h1);
	endtask : wait_st

	task automatic wait_frame();
		int n;
		n = 0;
		while (frames == f0 && n < 1000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 1000) err_total++;
	endtask : wait_frame

	task automatic clr();
		wr(OFF_ICLR, 32'h0000_00FF, RESP_OKAY);
	endtask : clr

	task automatic print_verdict();
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		print_verdict();
	end

	initial begin
		rst = 1'b1;
		{awaddr, araddr, wdata, awvalid, wvalid, arvalid, sclk_i} = '0;
		{bready, rready} = 2'b11;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk({31'h0, irq}, 32'h0);
		chk({31'h0, asc_txd}, 32'h1);
		rchk(OFF_A_BAUD, 32'h18);
		rchk(OFF_S_BAUD, 32'h18);
		rchk(OFF_A_CTRL, 32'h0);
		rd_reg(6'h30, rd, RESP_SLVERR);
		chk(rd, 32'h0);
		wr(6'h34, 32'h1, RESP_SLVERR);
		wr(OFF_STATE, 32'h0000_FFFF, RESP_OKAY);
		rchk(OFF_STATE, 32'h0);
		wr(OFF_A_BAUD, 32'h0, RESP_OKAY);
		wr(OFF_IEN, 32'h0000_00FF, RESP_OKAY);
		foreach (rows[k]) begin
			wr(OFF_A_CTRL, 32'(rows[k].ctrl), RESP_OKAY);
			f0 = frames;
			wr(OFF_A_TX, 32'(rows[k].data), RESP_OKAY);
			wait_st(ST_ATX);
			wait_frame();
			chk(32'(got), 32'(rows[k].line));
			chk(32'({irq, irq_req}), 32'h41);
			clr();
		end
		// Two stop bits keep the transmitter busy past the end of a one-stop frame.
		wr(OFF_A_CTRL, 32'h0000_0009, RESP_OKAY);
		wr(OFF_A_TX, 32'h0000_0033, RESP_OKAY);
		repeat (166) @(posedge clk_sys);
		rchk(OFF_STATE, 32'h0000_0002);
		wait_st(ST_ATX);
		clr();
		wr(OFF_A_CTRL, 32'h41, RESP_OKAY);
		i_far.send(10'h13C, 9);
		wait_st(ST_ARX);
		rchk(OFF_A_RX, 32'h3C);
		clr();
		i_far.send(10'h111, 9);
		i_far.send(10'h122, 9);
		wait_st(ST_AOE);
		chk(32'(irq_req), 32'h6);
		rchk(OFF_A_RX, 32'h22);
		clr();
		i_far.send(10'h055, 9);
		wait_st(ST_AFE);
		wr(OFF_IEN, 32'h0, RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_IEN, 32'h0000_00FF, RESP_OKAY);
		chk({31'h0, irq_req[2]}, 32'h1);
		clr();
		chk({31'h0, irq}, 32'h0);
		wr(OFF_A_CTRL, 32'h11, RESP_OKAY);
		i_far.send(10'h207, 10);
		wait_st(ST_APE);
		rchk(OFF_A_RX, 32'h0000_0007);
		clr();
		wr(OFF_A_CTRL, 32'h181, RESP_OKAY);
		i_far.send(10'h25A, 10);
		i_far.send(10'h3A6, 10);
		wait_st(ST_ARX);
		rchk(OFF_ISTAT, 32'h2);
		rchk(OFF_A_RX, 32'h1A6);
		clr();
		wr(OFF_A_CTRL, 32'h205, RESP_OKAY);
		wr(OFF_A_TX, 32'h1C3, RESP_OKAY);
		wait_st(ST_ARX);
		rchk(OFF_A_RX, 32'h1C3);
		wait_st(ST_ATX);
		clr();
		wr(OFF_A_CTRL, 32'h3, RESP_OKAY);
		wr(OFF_A_TX, 32'h5A, RESP_OKAY);
		wait_st(ST_ARX);
		rchk(OFF_A_RX, 32'hFF);
		chk({31'h0, asc_sclk}, 32'h0);
		clr();
		wr(OFF_S_BAUD, 32'h3, RESP_OKAY);
		wr(OFF_S_CTRL, 32'hF7, RESP_OKAY);
		i_far.load(16'hA5C3);
		wr(OFF_S_TX, 32'h1234, RESP_OKAY);
		wait_st(ST_STX);
		chk(32'(cap), 32'h1234);
		chk({31'h0, sclk_oe_n}, 32'h0);
		chk(32'(irq_req), 32'h18);
		rchk(OFF_S_RX, 32'hA5C3);
		clr();
		wr(OFF_S_CTRL, 32'h73, RESP_OKAY);
		i_far.load(16'hA5C3);
		wr(OFF_S_TX, 32'hB1, RESP_OKAY);
		wait_st(ST_STX);
		chk(32'(cap[7:0]), 32'h8D);
		clr();
		i_far.load(16'hA5C3);
		wr(OFF_S_TX, 32'hB1, RESP_OKAY);
		wait_st(ST_SOE);
		chk(32'(irq_req), 32'h38);
		rchk(OFF_S_RX, 32'hA5);
		clr();
		// Slave, LSB first, four bits, looped back, clocked by the bench as external master.
		wr(OFF_S_CTRL, 32'h0000_0039, RESP_OKAY);
		wr(OFF_S_TX, 32'h0000_0006, RESP_OKAY);
		repeat (8) begin
			sclk_i <= !sclk_i;
			repeat (3) @(posedge clk_sys);
		end
		wait_st(ST_SRX);
		chk({31'h0, sclk_oe_n}, 32'h1);
		chk(32'(irq_req), 32'h18);
		rchk(OFF_S_RX, 32'h0000_0006);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk({31'h0, irq}, 32'h0);
		rchk(OFF_S_CTRL, 32'h0);
		rchk(OFF_A_BAUD, 32'h18);
		print_verdict();
	end
endmodule : dual_serial_channels_tb
